// ---- uci_irq_ctrl.sv ----
// USB core interrupt collector: sticky requests, enables, vector code and one CPU interrupt.
// Assumes all event, busy and token inputs come from core logic on CLK, no synchronisers.
// Behaviour
// - Suspend flag sets after bus idle for 3 ms; software writes one to clear.
// - Event flags clear at power-on reset or by writing one, never at processor reset.
// - SETUP token received sets the setup token flag, bit 2.
// - Start-of-frame packet received sets the frame start flag, bit 1.
// - Setup data flag, bit 0, sets once all eight setup bytes are stored.
// - Writing one clears an event flag; writing zero leaves it.
// - Disabled endpoint request stays stored; enabled set request raises the interrupt.
// - Endpoint enables gate only the interrupt, never endpoint traffic.
// - Each event enable bit masks its matching flag at bits 4 to 0.
// - Unarmed bulk IN endpoint 0-6 gets IN token: NAK and set its request.
// - IN-NAK interrupt needs global enable bit 5 and the endpoint enable.
// - Writing one clears an IN-NAK request; the register shows which endpoints.
// - Each endpoint IN-NAK enable bit permits that endpoint's interrupt.
// - Auto-vector enable is bit 0 of the breakpoint and auto-vector register.
// - Endpoint request sets when its busy flag falls, regardless of enable.
// - Detected bus reset sets the bus reset flag, bit 4.
// - While the interrupt is raised, vector code register names the source.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module uci_irq_ctrl
   import uci_pkg::*;
#(
   parameter int SUSP_CYCLES = SUSPEND_IDLE_CYCLES
) (
   input wire logic CLK, // core clock, 40 MHz
   input wire logic RESET, // power-on reset, async, active high
   input wire logic CPU_RESET, // processor-only reset, sync, active high
   input wire logic [15:0] ADDR, // register address
   input wire logic [7:0] WDATA, // register write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   output logic [7:0] RDATA, // read data, cycle after RD
   input wire logic BUS_ACTIVITY, // level, high while the bus shows activity
   input wire logic SETUP_TOKEN, // pulse, SETUP token received
   input wire logic SOF_RX, // pulse, start-of-frame packet received
   input wire logic SETUP_DATA_DONE, // pulse, eight setup bytes stored
   input wire logic BUS_RESET_DET, // pulse, bus reset detected
   input wire logic [7:0] IN_BUSY, // IN endpoint busy flags
   input wire logic [7:0] OUT_BUSY, // OUT endpoint busy flags
   input wire logic [6:0] IN_TOKEN, // pulse, IN token to bulk IN endpoint 0-6
   output logic [6:0] IN_NAK_REPLY, // NAK reply request per endpoint
   output logic USB_CPU_INTERRUPT, // level interrupt to the processor
   output logic [4:0] VECTOR_CODE, // current interrupt source code
   output logic AUTO_VECTOR_ON // auto-vector feature enabled
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] in_ien;
      logic [7:0] out_ien;
      logic [7:0] usb_ien;
      logic [7:0] nak_ien;
      logic [7:0] bav;
      logic [4:0] vec;
      logic [7:0] rdata;
      logic [7:0] in_prev;
      logic [7:0] out_prev;
      logic [IDLE_CNT_W-1:0] idle_cnt;
      logic idle_fired;
   } uci_state_t;

   localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = IDLE_CNT_W'(SUSP_CYCLES - 1);

   uci_state_t st_q;
   uci_state_t st_d;
   logic [7:0] in_irq;
   logic [7:0] out_irq;
   logic [5:0] usb_irq;
   logic [6:0] nak_irq;
   logic [7:0] in_set;
   logic [7:0] out_set;
   logic [5:0] usb_set;
   logic [6:0] nak_set;
   logic [7:0] in_clr;
   logic [7:0] out_clr;
   logic [5:0] usb_clr;
   logic [6:0] nak_clr;
   logic [7:0] in_act;
   logic [7:0] out_act;
   logic [5:0] usb_act;
   logic susp_evt;
   logic [4:0] src_code;

   // ------------------------------------------------------------
   // Source priority
   // ------------------------------------------------------------
   // Lowest code wins, so bus events outrank endpoint traffic
   function automatic logic [4:0] pick_source(input logic [5:0] u, input logic [7:0] ia,
                                              input logic [7:0] oa);
      logic [4:0] res;
      res = RST_VECTOR;
      for (int i = NUM_EP - 1; i >= 0; i--) begin
         if (oa[i]) begin
            res = VEC_EP_BASE + 5'(2 * i + 1);
         end
         if (ia[i]) begin
            res = VEC_EP_BASE + 5'(2 * i);
         end
      end
      for (int i = NUM_USB_EVENTS - 1; i >= 0; i--) begin
         if (u[i]) begin
            res = 5'(i);
         end
      end
      return res;
   endfunction : pick_source

   // ------------------------------------------------------------
   // Request events
   // ------------------------------------------------------------
   // Busy is the armed state; the NAK itself never depends on any enable
   assign IN_NAK_REPLY = IN_TOKEN & ~IN_BUSY[6:0];
   assign nak_set = IN_NAK_REPLY;
   assign in_set = st_q.in_prev & ~IN_BUSY;
   assign out_set = st_q.out_prev & ~OUT_BUSY;
   assign susp_evt = !BUS_ACTIVITY && !st_q.idle_fired && (st_q.idle_cnt == IDLE_LAST);

   always_comb begin
      usb_set = '0;
      usb_set[BIT_SETUP_DATA] = SETUP_DATA_DONE;
      usb_set[BIT_FRAME_START] = SOF_RX;
      usb_set[BIT_SETUP_TOKEN] = SETUP_TOKEN;
      usb_set[BIT_SUSPEND] = susp_evt;
      usb_set[BIT_BUS_RESET] = BUS_RESET_DET;
      usb_set[BIT_IN_NAK] = |nak_set;
   end

   // Write-one-to-clear; a read-modify-write by software would clear every pending bit
   assign in_clr = (WR && ADDR == OFF_IN_IRQS) ? WDATA : '0;
   assign out_clr = (WR && ADDR == OFF_OUT_IRQS) ? WDATA : '0;
   assign usb_clr = (WR && ADDR == OFF_USB_IRQS) ? WDATA[5:0] : '0;
   assign nak_clr = (WR && ADDR == OFF_NAK_IRQS) ? WDATA[6:0] : '0;

   // ------------------------------------------------------------
   // Flag banks, power-on reset only
   // ------------------------------------------------------------
   uci_flag_bank #(.W(NUM_EP)) u_in_flags (
      .CLK(CLK),
      .RESET(RESET),
      .set_vec(in_set),
      .clr_vec(in_clr),
      .flags(in_irq)
   );

   uci_flag_bank #(.W(NUM_EP)) u_out_flags (
      .CLK(CLK),
      .RESET(RESET),
      .set_vec(out_set),
      .clr_vec(out_clr),
      .flags(out_irq)
   );

   uci_flag_bank #(.W(NUM_USB_EVENTS)) u_usb_flags (
      .CLK(CLK),
      .RESET(RESET),
      .set_vec(usb_set),
      .clr_vec(usb_clr),
      .flags(usb_irq)
   );

   uci_flag_bank #(.W(NUM_NAK_EP)) u_nak_flags (
      .CLK(CLK),
      .RESET(RESET),
      .set_vec(nak_set),
      .clr_vec(nak_clr),
      .flags(nak_irq)
   );

   // ------------------------------------------------------------
   // Interrupt gating
   // ------------------------------------------------------------
   assign in_act = in_irq & st_q.in_ien;
   assign out_act = out_irq & st_q.out_ien;

   always_comb begin
      usb_act = usb_irq[5:0] & st_q.usb_ien[5:0];
      // Summary flag alone never interrupts; the requesting endpoint must also be enabled
      usb_act[BIT_IN_NAK] = st_q.usb_ien[BIT_IN_NAK] && |(nak_irq & st_q.nak_ien[6:0]);
   end

   assign USB_CPU_INTERRUPT = |usb_act || |in_act || |out_act;
   assign src_code = pick_source(usb_act, in_act, out_act);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.rdata = RST_READ;
      st_d.in_prev = IN_BUSY;
      st_d.out_prev = OUT_BUSY;
      // Idle timer restarts on any activity and fires once per idle period
      if (BUS_ACTIVITY) begin
         st_d.idle_cnt = '0;
         st_d.idle_fired = 1'b0;
      end else if (st_q.idle_cnt == IDLE_LAST) begin
         st_d.idle_fired = 1'b1;
      end else begin
         st_d.idle_cnt = st_q.idle_cnt + 1'b1;
      end
      if (USB_CPU_INTERRUPT) begin
         st_d.vec = src_code;
      end
      if (WR) begin
         if (ADDR == OFF_IN_IENS) begin
            st_d.in_ien = WDATA;
         end else if (ADDR == OFF_OUT_IENS) begin
            st_d.out_ien = WDATA;
         end else if (ADDR == OFF_USB_IENS) begin
            st_d.usb_ien = WDATA;
         end else if (ADDR == OFF_NAK_IENS) begin
            st_d.nak_ien = WDATA;
         end else if (ADDR == OFF_BAV) begin
            st_d.bav = WDATA & BAV_WRITE_MASK;
         end
      end
      if (RD) begin
         if (ADDR == OFF_VECTOR_CODE) begin
            st_d.rdata = {1'b0, st_q.vec, 2'b00};
         end else if (ADDR == OFF_IN_IRQS) begin
            st_d.rdata = in_irq;
         end else if (ADDR == OFF_OUT_IRQS) begin
            st_d.rdata = out_irq;
         end else if (ADDR == OFF_USB_IRQS) begin
            st_d.rdata = {2'b00, usb_irq};
         end else if (ADDR == OFF_IN_IENS) begin
            st_d.rdata = st_q.in_ien;
         end else if (ADDR == OFF_OUT_IENS) begin
            st_d.rdata = st_q.out_ien;
         end else if (ADDR == OFF_USB_IENS) begin
            st_d.rdata = st_q.usb_ien;
         end else if (ADDR == OFF_BAV) begin
            st_d.rdata = st_q.bav;
         end else if (ADDR == OFF_NAK_IRQS) begin
            st_d.rdata = {1'b0, nak_irq};
         end else if (ADDR == OFF_NAK_IENS) begin
            st_d.rdata = st_q.nak_ien;
         end
      end
      // Processor reset restores enables and vector but leaves the request flags
      if (CPU_RESET) begin
         st_d.in_ien = RST_ENABLES;
         st_d.out_ien = RST_ENABLES;
         st_d.usb_ien = RST_ENABLES;
         st_d.nak_ien = RST_ENABLES;
         st_d.bav = RST_BAV;
         st_d.vec = RST_VECTOR;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign RDATA = st_q.rdata;
   assign VECTOR_CODE = st_q.vec;
   assign AUTO_VECTOR_ON = st_q.bav[BIT_AUTO_VECTOR];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_susp_after_idle;
      @(posedge CLK) disable iff (RESET)
      $rose(usb_irq[BIT_SUSPEND]) |-> $past(st_q.idle_cnt) == IDLE_LAST && !$past(BUS_ACTIVITY);
   endproperty
   a_susp_after_idle: assert property (p_susp_after_idle) else $error("suspend flag set early");

   property p_flags_survive_cpu_reset;
      @(posedge CLK) disable iff (RESET)
      (CPU_RESET && !(WR && ADDR == OFF_USB_IRQS)) |=> (usb_irq & $past(usb_irq)) == $past(usb_irq);
   endproperty
   a_flags_survive_cpu_reset: assert property (p_flags_survive_cpu_reset) else $error("flag lost on cpu reset");

   property p_setup_token_sets;
      @(posedge CLK) disable iff (RESET)
      SETUP_TOKEN |=> usb_irq[BIT_SETUP_TOKEN];
   endproperty
   a_setup_token_sets: assert property (p_setup_token_sets) else $error("setup token flag not set");

   property p_sof_sets;
      @(posedge CLK) disable iff (RESET)
      SOF_RX |=> usb_irq[BIT_FRAME_START];
   endproperty
   a_sof_sets: assert property (p_sof_sets) else $error("frame start flag not set");

   property p_setup_data_cause;
      @(posedge CLK) disable iff (RESET)
      $rose(usb_irq[BIT_SETUP_DATA]) |-> $past(SETUP_DATA_DONE);
   endproperty
   a_setup_data_cause: assert property (p_setup_data_cause) else $error("setup data flag without cause");

   property p_bus_reset_sets;
      @(posedge CLK) disable iff (RESET)
      BUS_RESET_DET |=> usb_irq[BIT_BUS_RESET];
   endproperty
   a_bus_reset_sets: assert property (p_bus_reset_sets) else $error("bus reset flag not set");

   property p_w1c_clears;
      @(posedge CLK) disable iff (RESET)
      (WR && ADDR == OFF_USB_IRQS && WDATA[BIT_SETUP_TOKEN] && !SETUP_TOKEN) |=> !usb_irq[BIT_SETUP_TOKEN];
   endproperty
   a_w1c_clears: assert property (p_w1c_clears) else $error("write one did not clear flag");

   property p_masked_quiet;
      @(posedge CLK) disable iff (RESET)
      (st_q.in_ien == '0 && st_q.out_ien == '0 && st_q.usb_ien == '0) |-> !USB_CPU_INTERRUPT;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("interrupt while all masked");

   property p_busy_fall_sets;
      @(posedge CLK) disable iff (RESET)
      (st_q.in_prev[3] && !IN_BUSY[3]) |=> in_irq[3];
   endproperty
   a_busy_fall_sets: assert property (p_busy_fall_sets) else $error("busy fall did not set request");

   property p_nak_unarmed;
      @(posedge CLK) disable iff (RESET)
      (IN_TOKEN[2] && !IN_BUSY[2]) |-> IN_NAK_REPLY[2] ##1 (nak_irq[2] && usb_irq[BIT_IN_NAK]);
   endproperty
   a_nak_unarmed: assert property (p_nak_unarmed) else $error("unarmed IN token not NAKed");

   property p_nak_needs_global;
      @(posedge CLK) disable iff (RESET)
      !st_q.usb_ien[BIT_IN_NAK] |-> !usb_act[BIT_IN_NAK];
   endproperty
   a_nak_needs_global: assert property (p_nak_needs_global) else $error("nak irq without global enable");

   property p_vector_tracks;
      @(posedge CLK) disable iff (RESET)
      (USB_CPU_INTERRUPT && !CPU_RESET) |=> VECTOR_CODE == $past(src_code);
   endproperty
   a_vector_tracks: assert property (p_vector_tracks) else $error("vector code not updated");

   property p_auto_vector_write;
      @(posedge CLK) disable iff (RESET)
      (WR && ADDR == OFF_BAV && !CPU_RESET) |=> AUTO_VECTOR_ON == $past(WDATA[BIT_AUTO_VECTOR]);
   endproperty
   a_auto_vector_write: assert property (p_auto_vector_write) else $error("auto vector bit wrong");

   c_suspend: cover property (@(posedge CLK) disable iff (RESET) $rose(usb_irq[BIT_SUSPEND]));
   c_nak_irq: cover property (@(posedge CLK) disable iff (RESET) usb_act[BIT_IN_NAK]);
   c_ep_irq: cover property (@(posedge CLK) disable iff (RESET) |in_act ##1 !USB_CPU_INTERRUPT);
   c_set_and_clear: cover property (@(posedge CLK) disable iff (RESET) SOF_RX && usb_clr[BIT_FRAME_START]);

endmodule : uci_irq_ctrl

// ---- uci_pkg.sv ----
// USB core interrupt collector: register offsets, field positions, reset values and counts.
// Assumes an 8-bit register port with 16-bit addresses and a 40 MHz core clock.
package uci_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [15:0] OFF_VECTOR_CODE = 16'h7fa8;
   localparam logic [15:0] OFF_IN_IRQS = 16'h7fa9;
   localparam logic [15:0] OFF_OUT_IRQS = 16'h7faa;
   localparam logic [15:0] OFF_USB_IRQS = 16'h7fab;
   localparam logic [15:0] OFF_IN_IENS = 16'h7fac;
   localparam logic [15:0] OFF_OUT_IENS = 16'h7fad;
   localparam logic [15:0] OFF_USB_IENS = 16'h7fae;
   localparam logic [15:0] OFF_BAV = 16'h7faf;
   localparam logic [15:0] OFF_NAK_IRQS = 16'h7fb0;
   localparam logic [15:0] OFF_NAK_IENS = 16'h7fb1;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_SETUP_DATA = 0;
   localparam int BIT_FRAME_START = 1;
   localparam int BIT_SETUP_TOKEN = 2;
   localparam int BIT_SUSPEND = 3;
   localparam int BIT_BUS_RESET = 4;
   localparam int BIT_IN_NAK = 5;
   localparam int BIT_AUTO_VECTOR = 0;
   localparam int VEC_CODE_LSB = 2;
   localparam int NUM_NAK_EP = 7;
   localparam int NUM_EP = 8;
   localparam int NUM_USB_EVENTS = 6;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_ENABLES = 8'h00;
   localparam logic [7:0] RST_BAV = 8'h00;
   localparam logic [4:0] RST_VECTOR = 5'h00;
   localparam logic [7:0] RST_READ = 8'h00;

   // ------------------------------------------------------------
   // Vector codes
   // ------------------------------------------------------------
   // USB events take codes 0..5, endpoints follow as IN0, OUT0, IN1 ... OUT7
   localparam logic [4:0] VEC_EP_BASE = 5'h06;
   localparam logic [7:0] BAV_WRITE_MASK = 8'h0f;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int SUSPEND_IDLE_US = 3000;
   localparam int CLK_MHZ = 40;
   localparam int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_US * CLK_MHZ;
   localparam int IDLE_CNT_W = 17;

endpackage : uci_pkg

// ---- uci_flag_bank.sv ----
// Bank of sticky request flags, set by hardware events and cleared by writing ones.
// Assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ps
module uci_flag_bank
   import uci_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic CLK, // core clock
   input wire logic RESET, // power-on reset, async, active high
   input wire logic [W-1:0] set_vec, // one-cycle set per flag
   input wire logic [W-1:0] clr_vec, // write-one-to-clear per flag
   output logic [W-1:0] flags // sticky flags
);
   typedef struct packed {
      logic [W-1:0] flags;
   } uci_fb_state_t;

   uci_fb_state_t st_q;
   uci_fb_state_t st_d;

   // A set in the same cycle as a clear wins, so no event is lost
   always_comb begin
      st_d = st_q;
      st_d.flags = (st_q.flags & ~clr_vec) | set_vec;
   end

   // Only power-on reset touches the flags; processor reset does not reach here
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign flags = st_q.flags;

endmodule : uci_flag_bank

// ---- uci_cpu_model.sv ----
// Processor-side model: takes the USB interrupt line into its own interrupt logic.
// Assumes the level interrupt of uci_irq_ctrl on the same clock, no synchroniser.
`timescale 1ns/1ps
module uci_cpu_model (
   input wire logic clk, // core clock
   input wire logic reset, // power-on reset, async, active high
   input wire logic usb_cpu_interrupt, // level request from the collector
   input wire logic usb_cpu_irq_enable, // processor's USB interrupt input enable
   input wire logic global_irq_enable, // processor's global interrupt enable
   output logic irq_taken // high while the processor accepts the request
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic taken;
   } uci_cpu_state_t;

   uci_cpu_state_t st_q;
   uci_cpu_state_t st_d;

   // Both enables must be set or the request is held off; clearing stays with software
   always_comb begin
      st_d = st_q;
      st_d.taken = usb_cpu_interrupt & usb_cpu_irq_enable & global_irq_enable;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign irq_taken = st_q.taken;
endmodule : uci_cpu_model

// ---- uci_irq_ctrl_tb_top.sv ----
// Self-checking bench for the interrupt collector, driving its register port and events.
// Assumes SUSP_CYCLES of 20 and the processor model in uci_cpu_model.
`timescale 1ns/1ps
module uci_irq_ctrl_tb_top
   import uci_pkg::*;
;
   logic clk, reset, cpu_reset, wr_s, rd_s, bus_activity, setup_token, sof_rx, setup_done;
   logic bus_reset_det, intr, auto_vec, cpu_en, glob_en, taken;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, in_busy, out_busy, rv;
   logic [6:0] in_token, nak_reply;
   logic [4:0] vec;
   int n_fail, check_count, cyc;
   int vec_list[4] = '{0, 1, 2, 4};

   uci_irq_ctrl #(.SUSP_CYCLES(20)) uci_irq_ctrl_i (.CLK(clk), .RESET(reset),
      .CPU_RESET(cpu_reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .BUS_ACTIVITY(bus_activity), .SETUP_TOKEN(setup_token), .SOF_RX(sof_rx),
      .SETUP_DATA_DONE(setup_done), .BUS_RESET_DET(bus_reset_det), .IN_BUSY(in_busy),
      .OUT_BUSY(out_busy), .IN_TOKEN(in_token), .IN_NAK_REPLY(nak_reply),
      .USB_CPU_INTERRUPT(intr), .VECTOR_CODE(vec), .AUTO_VECTOR_ON(auto_vec));

   uci_cpu_model uci_cpu_model_i (.clk(clk), .reset(reset), .usb_cpu_interrupt(intr),
      .usb_cpu_irq_enable(cpu_en), .global_irq_enable(glob_en), .irq_taken(taken));

   // ------------------------------------------------------------
   // Clock, verdict and hang guard
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic print_verdict;
      if (n_fail == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic chkrd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : chkrd

   // Bit map: 0 setup data, 1 frame start, 2 setup token, 4 bus reset
   task automatic ev(input logic [4:0] m);
      @(posedge clk);
      {bus_reset_det, setup_token, sof_rx, setup_done} <= {m[4], m[2], m[1], m[0]};
      @(posedge clk);
      {bus_reset_det, setup_token, sof_rx, setup_done} <= 4'h0;
   endtask : ev

   task automatic chk_vec(input logic [4:0] code);
      @(posedge clk);
      #1;
      chk({3'h0, vec}, {3'h0, code});
   endtask : chk_vec

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      {reset, cpu_reset, wr_s, rd_s, setup_token, sof_rx, setup_done, bus_reset_det} = 8'h80;
      {bus_activity, in_busy, out_busy, in_token} = {1'b1, 8'hff, 8'hff, 7'h00};
      {addr, wdata, cpu_en, glob_en} = {OFF_VECTOR_CODE, 8'h00, 2'b00};
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         chkrd(OFF_VECTOR_CODE + 16'(i), 8'h00);
      end
      chkrd(16'h7fb2, 8'h00);
      foreach (vec_list[k]) begin
         ev(5'h01 << vec_list[k]);
         chkrd(OFF_USB_IRQS, 8'h01 << vec_list[k]);
         wr(OFF_USB_IRQS, ~(8'h01 << vec_list[k]));
         chkrd(OFF_USB_IRQS, 8'h01 << vec_list[k]);
         chk(intr, 1'b0);
         wr(OFF_USB_IENS, 8'h01 << vec_list[k]);
         #1 chk(intr, 1'b1);
         chk_vec(5'(vec_list[k]));
         chkrd(OFF_VECTOR_CODE, 8'(vec_list[k]) << VEC_CODE_LSB);
         wr(OFF_USB_IRQS, 8'h01 << vec_list[k]);
         #1 chk(intr, 1'b0);
         wr(OFF_USB_IENS, 8'h00);
      end
      // Suspend needs 20 idle edges in a row
      wr(OFF_USB_IENS, 8'h08);
      @(posedge clk);
      bus_activity <= 1'b0;
      repeat (19) @(posedge clk);
      #1 chk(intr, 1'b0);
      @(posedge clk);
      #1 chk(intr, 1'b1);
      bus_activity <= 1'b1;
      wr(OFF_USB_IRQS, 8'h08);
      #1 chk(intr, 1'b0);
      // Processor-only reset keeps flags but drops enables
      ev(5'h02);
      wr(OFF_USB_IENS, 8'h02);
      @(posedge clk);
      cpu_reset <= 1'b1;
      @(posedge clk);
      cpu_reset <= 1'b0;
      #1 chk(intr, 1'b0);
      chkrd(OFF_USB_IRQS, 8'h02);
      chkrd(OFF_USB_IENS, 8'h00);
      wr(OFF_USB_IRQS, 8'h02);
      // Endpoint busy falls
      @(posedge clk);
      in_busy <= 8'hf7;
      out_busy <= 8'hfb;
      chkrd(OFF_IN_IRQS, 8'h08);
      chkrd(OFF_OUT_IRQS, 8'h04);
      chk(intr, 1'b0);
      {cpu_en, glob_en} <= 2'b11;
      wr(OFF_IN_IENS, 8'h08);
      #1 chk(intr, 1'b1);
      chk_vec(5'd12);
      chk(taken, 1'b1);
      glob_en <= 1'b0;
      wr(OFF_OUT_IENS, 8'h04);
      chk_vec(5'd11);
      chk(taken, 1'b0);
      wr(OFF_IN_IRQS, 8'h08);
      wr(OFF_OUT_IRQS, 8'h04);
      #1 chk(intr, 1'b0);
      // Unarmed bulk IN endpoint 1 gets a token; the reply must come while the NAK enables are still clear
      @(posedge clk);
      in_busy <= 8'hfd;
      in_token <= 7'h02;
      #1 chk({1'b0, nak_reply}, 8'h02);
      @(posedge clk);
      in_token <= 7'h00;
      chkrd(OFF_NAK_IRQS, 8'h02);
      chkrd(OFF_USB_IRQS, 8'h20);
      wr(OFF_NAK_IENS, 8'h02);
      #1 chk(intr, 1'b0);
      wr(OFF_USB_IENS, 8'h20);
      #1 chk(intr, 1'b1);
      chk_vec(5'd5);
      wr(OFF_NAK_IENS, 8'h00);
      #1 chk(intr, 1'b0);
      wr(OFF_NAK_IENS, 8'h02);
      wr(OFF_NAK_IRQS, 8'h02);
      #1 chk(intr, 1'b0);
      chkrd(OFF_NAK_IRQS, 8'h00);
      // Auto-vector bit and an unmapped write
      wr(OFF_BAV, 8'hff);
      #1 chk(auto_vec, 1'b1);
      chkrd(OFF_BAV, 8'h0f);
      wr(OFF_BAV, 8'h0e);
      #1 chk(auto_vec, 1'b0);
      wr(16'h7fb2, 8'hff);
      chkrd(16'h7fb2, 8'h00);
      print_verdict();
   end

endmodule : uci_irq_ctrl_tb_top
